// file: inc/timer_prescaler_defs.vh
`ifndef TIMER_PRESCALER_DEFS_VH
`define TIMER_PRESCALER_DEFS_VH

// Control register index; its byte address is four times the index.
`define GTC_INDEX 8'h43
`define GTC_ADDR 12'h10c
`define CLKSEL_ADDR 12'h110
`define STATUS_ADDR 12'h114

// Field positions of the general timer control and clock select registers.
`define GTC_HOLD_BIT 7
`define GTC_ASYNC_RST_BIT 1
`define GTC_SHARED_RST_BIT 0
`define SEL0_LSB 0
`define SEL1_LSB 4
`define GTC_RESET 8'h00

// Clock select encodings.
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7

// Divider ratios.
`define DIV_A 8
`define DIV_B 64
`define DIV_C 256
`define DIV_D 1024

`endif

// file: hw/ext_edge_detect.v
`timescale 1ns/1ps
`include "timer_prescaler_defs.vh"

module ext_edge_detect (
    input wire core_clk,
    input wire rst_b,
    input wire extPin,
    output wire riseTick,
    output wire fallTick
);

    reg halfLatch;
    reg syncStage;
    reg lastStage;

    // ==========================================
    // Pin sampling
    // Latch transparent while the clock is high, modelled as a falling-edge
    // stage ahead of the rising-edge flops.
    always @(negedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            halfLatch <= 1'b0;
        end else begin
            halfLatch <= extPin;
        end
    end

    // Rising-edge flops sample once per cycle.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            syncStage <= 1'b0;
            lastStage <= 1'b0;
        end else begin
            syncStage <= halfLatch;
            lastStage <= syncStage;
        end
    end

    // Edge decode on the synchronised level.
    assign riseTick = syncStage & ~lastStage;
    assign fallTick = ~syncStage & lastStage;

endmodule

// file: hw/shared_timer_prescaler.v
`timescale 1ns/1ps
`include "timer_prescaler_defs.vh"

// Behaviour
// - select 1 ticks every clock cycle the shared reset is clear
// - taps divide by 8, 64, 256, 1024
// - one free divider shared by both timers
// - first prescaled tick within 1 to N+1
// - prescaler reset restarts phase for both
// - pin sampled by rising-edge flops, edge detect
// - input latch transparent while clock high
// - select 7 rising, 6 falling edge ticks
// - pin edge to tick 1.5 to 2.5 cycles
// - external ticks bypass the divider
// - hold mode keeps prescaler reset bits
// - clearing hold clears both reset bits
// - shared reset self-clears unless hold set
// - select 0 gives no ticks
module shared_timer_prescaler #(
    parameter DIV_W = 10
) (
    input wire core_clk,
    input wire rst_b,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire extCountPin0,
    input wire extCountPin1,
    output reg timerTick0,
    output reg timerTick1,
    output reg asyncPrescalerReset
);

    localparam [1:0] RESP_OKAY = 2'h0;
    localparam [1:0] RESP_SLVERR = 2'h2;
    localparam [1:0] REG_NONE = 2'h0;
    localparam [1:0] REG_CTRL = 2'h1;
    localparam [1:0] REG_SEL = 2'h2;
    localparam [1:0] REG_STATUS = 2'h3;

    reg syncHoldMode;
    reg sharedPrescalerReset;
    reg asyncResetBit;
    reg [2:0] clockSelect0;
    reg [2:0] clockSelect1;
    reg [DIV_W-1:0] divCount;
    reg [DIV_W-1:0] lastCount;
    reg [11:0] wrAddr;
    reg [31:0] wrData;
    reg [3:0] wrStrb;
    reg haveAddr;
    reg haveData;
    wire [3:0] tapPulse;
    wire rise0;
    wire fall0;
    wire rise1;
    wire fall1;
    wire doWrite;
    wire next_tick0;
    wire next_tick1;
    wire [1:0] wrReg;
    wire [1:0] rdReg;
    genvar tapIdx;

    // ==========================================
    // Shared divider
    // Free-running counter; it ignores both clock selects and is cleared only by rst_b
    // and by the shared prescaler reset, which holds it while asserted.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            divCount <= {DIV_W{1'b0}};
            lastCount <= {DIV_W{1'b0}};
        end else if (sharedPrescalerReset) begin
            divCount <= {DIV_W{1'b0}};
            lastCount <= {DIV_W{1'b0}};
        end else begin
            lastCount <= divCount;
            divCount <= divCount + {{(DIV_W-1){1'b0}}, 1'b1};
        end
    end

    // Low-bit mask of one tap; the ratio is cut to the divider width on purpose.
    function [DIV_W-1:0] tapMask;
        input integer idx;
        reg [31:0] ratio;
        begin
            case (idx)
                0: ratio = `DIV_A;
                1: ratio = `DIV_B;
                2: ratio = `DIV_C;
                default: ratio = `DIV_D;
            endcase
            ratio = ratio - 32'h00000001;
            tapMask = ratio[DIV_W-1:0];
        end
    endfunction

    // Tap pulses fire once per period when the low bits wrap to all ones, and
    // stay quiet while the shared reset holds the divider.
    generate
        for (tapIdx = 0; tapIdx < 4; tapIdx = tapIdx + 1) begin : g_tap
            assign tapPulse[tapIdx] = ((divCount & tapMask(tapIdx)) == tapMask(tapIdx))
                && !sharedPrescalerReset;
        end
    endgenerate

    // ==========================================
    // Clock select
    // Decoding used by both timers; the phase of the free divider decides
    // when the first prescaled tick lands after a select change.
    function selTick;
        input [2:0] sel;
        input [3:0] taps;
        input rise;
        input fall;
        input held;
        begin
            case (sel)
                `CS_STOP: selTick = 1'b0;
                `CS_DIV1: selTick = !held;
                `CS_DIV8: selTick = taps[0];
                `CS_DIV64: selTick = taps[1];
                `CS_DIV256: selTick = taps[2];
                `CS_DIV1024: selTick = taps[3];
                `CS_EXT_FALL: selTick = fall;
                `CS_EXT_RISE: selTick = rise;
                default: selTick = 1'b0;
            endcase
        end
    endfunction

    ext_edge_detect u_edge0 (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .extPin(extCountPin0),
        .riseTick(rise0),
        .fallTick(fall0)
    );

    ext_edge_detect u_edge1 (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .extPin(extCountPin1),
        .riseTick(rise1),
        .fallTick(fall1)
    );

    assign next_tick0 = selTick(clockSelect0, tapPulse, rise0, fall0, sharedPrescalerReset);
    assign next_tick1 = selTick(clockSelect1, tapPulse, rise1, fall1, sharedPrescalerReset);

    // Registered ticks; the extra flop gives the 1.5 to 2.5 cycle pin delay.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            timerTick0 <= 1'b0;
            timerTick1 <= 1'b0;
            asyncPrescalerReset <= 1'b0;
        end else begin
            timerTick0 <= next_tick0;
            timerTick1 <= next_tick1;
            asyncPrescalerReset <= asyncResetBit;
        end
    end

    // ==========================================
    // AXI4-Lite write path
    // Maps a byte address onto the register it names; both bus paths use it.
    function [1:0] regDecode;
        input [11:0] addr;
        begin
            case ({addr[11:2], 2'b00})
                `GTC_ADDR: regDecode = REG_CTRL;
                `CLKSEL_ADDR: regDecode = REG_SEL;
                `STATUS_ADDR: regDecode = REG_STATUS;
                default: regDecode = REG_NONE;
            endcase
        end
    endfunction

    // Decoded targets of the pending write and of the offered read.
    assign wrReg = regDecode(wrAddr);
    assign rdReg = regDecode(s_axi_araddr);

    // Address and data are captured independently in either order; the write
    // fires once, in the cycle before the response is raised.
    assign doWrite = haveAddr && haveData && !s_axi_bvalid;

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            haveAddr <= 1'b0;
            haveData <= 1'b0;
            wrAddr <= 12'h000;
            wrData <= 32'h00000000;
            wrStrb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wrAddr <= s_axi_awaddr;
                haveAddr <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wrData <= s_axi_wdata;
                wrStrb <= s_axi_wstrb;
                haveData <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                // Unmapped targets are refused and leave every register alone.
                if (wrReg == REG_NONE) begin
                    s_axi_bresp <= RESP_SLVERR;
                end else begin
                    s_axi_bresp <= RESP_OKAY;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                haveAddr <= 1'b0;
                haveData <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ==========================================
    // Control registers
    // Reset bits are held while hold mode is set and dropped together when
    // hold mode is written to zero.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            syncHoldMode <= 1'b0;
            sharedPrescalerReset <= 1'b0;
            asyncResetBit <= 1'b0;
            clockSelect0 <= `CS_STOP;
            clockSelect1 <= `CS_STOP;
        end else if (doWrite && wrReg == REG_CTRL && wrStrb[0]) begin
            syncHoldMode <= wrData[`GTC_HOLD_BIT];
            if (wrData[`GTC_HOLD_BIT]) begin
                sharedPrescalerReset <= wrData[`GTC_SHARED_RST_BIT] | sharedPrescalerReset;
                asyncResetBit <= wrData[`GTC_ASYNC_RST_BIT] | asyncResetBit;
            end else begin
                sharedPrescalerReset <= wrData[`GTC_SHARED_RST_BIT];
                asyncResetBit <= wrData[`GTC_ASYNC_RST_BIT];
            end
        end else begin
            // A new select acts on the next tick decision; the divider phase is
            // left alone, so the first prescaled tick may come early or late.
            if (doWrite && wrReg == REG_SEL && wrStrb[0]) begin
                clockSelect0 <= wrData[`SEL0_LSB +: 3];
                clockSelect1 <= wrData[`SEL1_LSB +: 3];
            end
            // Without hold mode both reset bits last a single cycle.
            if (!syncHoldMode) begin
                sharedPrescalerReset <= 1'b0;
                asyncResetBit <= 1'b0;
            end
        end
    end

    // ==========================================
    // AXI4-Lite read path
    // Read data is registered with rvalid and held until rready is seen.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (rdReg)
                REG_CTRL: s_axi_rdata <= {24'h000000, syncHoldMode, 5'h00,
                    asyncResetBit, sharedPrescalerReset};
                REG_SEL: s_axi_rdata <= {25'h0000000, clockSelect1, 1'b0,
                    clockSelect0};
                REG_STATUS: s_axi_rdata <= {{(32-DIV_W){1'b0}}, lastCount};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// file: testbench/stp_checker_properties.sv
`timescale 1ns/1ps
// ==========
// Bus handshake checks.
module stp_checker (
    input wire core_clk,
    input wire rst_b,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped early");
    rdata_stable_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("rdata changed while waiting");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp != 2'h1 && s_axi_bresp != 2'h3)
        else $error("bad write response code");
    write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready during response");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read ready during response");
endmodule
bind shared_timer_prescaler stp_checker u_chk (.*);

// file: testbench/timer_core_model.sv
`timescale 1ns/1ps
// ==========
// Two timer cores that count received ticks.
module timer_core_model (
    input wire core_clk,
    input wire clr,
    input wire tick0,
    input wire tick1,
    output int cnt0,
    output int cnt1
);
    // Each core advances once per tick it samples.
    always @(posedge core_clk) begin
        cnt0 <= clr ? 0 : cnt0 + tick0;
        cnt1 <= clr ? 0 : cnt1 + tick1;
    end
endmodule

// file: testbench/shared_timer_prescaler_tb.sv
`timescale 1ns/1ps
`include "timer_prescaler_defs.vh"
// ==========
// Bench top.
module shared_timer_prescaler_tb;
    logic core_clk = 1'h0, rst_b = 1'h0, awv = 1'h0, wv = 1'h0, bRdy = 1'h0;
    logic arv = 1'h0, rRdy = 1'h0, pin0 = 1'h0, pin1 = 1'h0, clr = 1'h0;
    logic [11:0] awa = 12'h0, ara = 12'h0;
    logic [31:0] wd = 32'h0, rd;
    logic [1:0] rs, bs;
    wire awr, wr, bv, arr, rv, t0, t1, apr;
    wire [1:0] br, rr;
    wire [31:0] rdat;
    int err_total = 0, n_tests = 0, cyc = 0, m0, m1, n0, n1;
    int dv[4] = '{`DIV_A, `DIV_B, `DIV_C, `DIV_D};
    shared_timer_prescaler u_dut (.core_clk(core_clk), .rst_b(rst_b),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bRdy),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rRdy),
        .extCountPin0(pin0), .extCountPin1(pin1), .timerTick0(t0), .timerTick1(t1),
        .asyncPrescalerReset(apr));
    timer_core_model u_core (.core_clk(core_clk), .clr(clr), .tick0(t0), .tick1(t1),
        .cnt0(m0), .cnt1(m1));
    // The clock toggles every half period and a hang is cut short.
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 10000) begin
            err_total++;
            end_of_test;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task end_of_test;
        if (err_total == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Write address and data are offered together and released when taken.
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 1'h0;
        tw = 1'h0;
        @(posedge core_clk);
        awa <= a; wd <= d; awv <= 1'h1; wv <= 1'h1;
        while (!(ta && tw)) begin
            @(negedge core_clk);
            ta = ta | (awv & awr);
            tw = tw | (wv & wr);
            @(posedge core_clk);
            if (ta) awv <= 1'h0;
            if (tw) wv <= 1'h0;
        end
        bRdy <= 1'h1;
        do @(negedge core_clk); while (bv !== 1'h1);
        bs = br;
        @(posedge core_clk);
        bRdy <= 1'h0;
    endtask
    task automatic axr(input logic [11:0] a);
        @(posedge core_clk);
        ara <= a; arv <= 1'h1; rRdy <= 1'h1;
        do @(negedge core_clk); while (arr !== 1'h1);
        @(posedge core_clk);
        arv <= 1'h0;
        do @(negedge core_clk); while (rv !== 1'h1);
        rd = rdat;
        rs = rr;
        @(posedge core_clk);
        rRdy <= 1'h0;
    endtask
    // Clears the cores, then lets exactly n edges of ticks accumulate.
    task win(input int n);
        @(posedge core_clk) clr <= 1'h1;
        @(posedge core_clk) clr <= 1'h0;
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    // Drives both pins and notes the cycle of the first tick, 0 for none.
    task automatic lat(input logic v);
        @(posedge core_clk) begin
            pin0 <= v;
            pin1 <= v;
        end
        n0 = 0;
        n1 = 0;
        for (int i = 1; i <= 8; i++) begin
            @(negedge core_clk);
            if (t0 === 1'h1 && n0 == 0) n0 = i;
            if (t1 === 1'h1 && n1 == 0) n1 = i;
        end
    endtask
    task t_regs;
        axr(`GTC_ADDR);
        chk(rd, 32'h0);
        chk(rs, 2'h0);
        axr(12'hffc);
        chk(rs, 2'h2);
        chk(rd, 32'h0);
        axw(12'hffc, 32'h83);
        chk(bs, 2'h2);
        axr(`GTC_ADDR);
        chk(rd, 32'h0);
    endtask
    task t_direct;
        axw(`CLKSEL_ADDR, 32'h1);
        win(20);
        chk(m0, 20);
        chk(m1, 0);
    endtask
    task t_taps;
        for (int i = 0; i < 4; i++) begin
            axw(`CLKSEL_ADDR, 32'h20 | (i + 2));
            win(2 * dv[i]);
            chk(m0, 2);
            chk(m1, dv[i] / 4);
        end
    endtask
    task t_reset;
        axw(`CLKSEL_ADDR, 32'h55);
        axw(`GTC_ADDR, 32'h1);
        n0 = 0;
        do begin
            @(negedge core_clk);
            n0++;
        end while (t1 !== 1'h1 && n0 < 1100);
        chk(n0 >= 1000 && n0 <= 1026, 1'h1);
        chk(t0, 1'h1);
        axr(`GTC_ADDR);
        chk(rd, 32'h0);
    endtask
    task t_hold;
        axw(`CLKSEL_ADDR, 32'h22);
        axw(`GTC_ADDR, 32'h83);
        chk(bs, 2'h0);
        axr(`GTC_ADDR);
        chk(rd, 32'h83);
        chk(apr, 1'h1);
        win(40);
        chk(m0 + m1, 0);
        axr(`STATUS_ADDR);
        chk(rd, 32'h0);
        axw(`GTC_ADDR, 32'h0);
        axr(`GTC_ADDR);
        chk(rd, 32'h0);
        chk(apr, 1'h0);
        win(16);
        chk(m0, 2);
        chk(m1, 2);
    endtask
    task t_ext;
        for (int s = 6; s < 8; s++) begin
            axw(`CLKSEL_ADDR, s | (s << 4));
            lat(1'h1);
            chk(n0 == 3, s == 7);
            chk(n1 == 3, s == 7);
            lat(1'h0);
            chk(n0 == 3, s == 6);
            chk(n1 == 3, s == 6);
        end
    endtask
    // Reset is held for five cycles before the scenarios run.
    initial begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'h1;
        t_regs;
        t_direct;
        t_taps;
        t_reset;
        t_hold;
        t_ext;
        end_of_test;
    end
endmodule
